// *** core/dsb_defs.vh ***
// Constants for the drive stop / brake / regen sequencer.
// Assumes a 100 MHz clock; voltages in volts, speed in rpm.
`ifndef DSB_DEFS_VH
`define DSB_DEFS_VH
`define DSB_CLK_MHZ          100
`define DSB_DIS_DELAY_MS     100
`define DSB_RAMP_MS          10
`define DSB_EMRG_TO_MS       5000
`define DSB_MS_CYCLES        (`DSB_CLK_MHZ * 1000)
`define DSB_STANDSTILL_RPM   16'h0005
`define DSB_ON_230           12'h190
`define DSB_ON_400           12'h2d0
`define DSB_ON_480           12'h348
`define DSB_OFF_230          12'h17c
`define DSB_OFF_400          12'h2a8
`define DSB_OFF_480          12'h320
`define DSB_OV_230           12'h1c2
`define DSB_OV_400           12'h320
`define DSB_OV_480           12'h384
`define DSB_ON_SPAN          12'h01e
`define DSB_CHECK_MS         2
`define DSB_CUR_LIMIT_MA     16'h0fa0
`define DSB_UV_RESET         12'h0c8
`define DSB_ADDR_CTRL        8'h00
`define DSB_ADDR_CFG         8'h04
`define DSB_ADDR_STAT        8'h08
`define DSB_ADDR_IRQ         8'h0c
`define DSB_ADDR_MASK        8'h10
`define DSB_ADDR_REGEN       8'h14
`define DSB_ADDR_BUS         8'h18
`define DSB_IRQ_OV           0
`define DSB_IRQ_PL           1
`define DSB_IRQ_UV           2
`define DSB_IRQ_RP           3
`define DSB_IRQ_BRK          4
`endif

// *** core/dsb_sequencer.v ***
// Drive stop, holding-brake, regen chopper and supply fault sequencer.
// Assumes synchronous inputs, AHB-Lite single word transfers, one clock.
// Operation
// - Brake sequence only with brake selected
// - 100 ms disable delay, 10 ms ramp
// - Brake at 5 rpm or 5 s timeout
// - Electrical braking before output stage off
// - Regen starts at class threshold voltage
// - Upper switch-on threshold per supply class
// - Switch-off threshold forms hysteresis band
// - Regen power exceeded disables regen switch
// - Periodic check flags overvoltage, shuts down
// - Ready contact opens with overvoltage shutdown
// - Shared bus thresholds raised by a software trim
// - Stop parameters select coast or braking
// - Phase-loss warning limits current 4 A
// - Phase-loss fault disables, opens ready
// - Undervoltage fault with configured response
// - Factory setting ramps down despite enable
`timescale 1ns/1ps
`include "dsb_defs.vh"
module dsb_sequencer
  #(
    parameter DIS_DELAY_CYC = `DSB_DIS_DELAY_MS * `DSB_MS_CYCLES,
    parameter RAMP_CYC      = `DSB_RAMP_MS * `DSB_MS_CYCLES,
    parameter EMRG_CYC      = `DSB_EMRG_TO_MS * `DSB_MS_CYCLES,
    parameter CHECK_CYC     = `DSB_CHECK_MS * `DSB_MS_CYCLES
  )
  (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        enable_in,
    input  wire [15:0] speed_rpm,
    input  wire [11:0] bus_volts,
    input  wire        phase_lost,
    input  wire        regen_avg_over,
    input  wire        regen_peak_over,
    output reg  [15:0] setpoint_out,
    output reg         output_stage_on,
    output reg         elec_braking,
    output reg         brake_out,
    output reg         regen_switch,
    output reg         ready_to_operate_contact,
    output reg         overvoltage_fault,
    output reg         phase_loss_fault,
    output reg         undervoltage_fault,
    output reg         mains_ready_fault,
    output reg         phase_loss_warning,
    output reg         regen_power_exceeded,
    output reg  [15:0] current_limit_ma,
    output wire        irq
  );

  localparam ST_RUN   = 2'd0;
  localparam ST_DELAY = 2'd1;
  localparam ST_OFF   = 2'd2;
  localparam ST_FAULT = 2'd3;
  localparam [11:0] TRIM_MAX = `DSB_ON_SPAN;

  // Class 0 = 230 V, 1 = 400 V, 2 = 480 V; kind 0 = switch-on, 1 = switch-off, 2 = overvoltage
  function [11:0] class_thr;
    input [1:0] cls;
    input [1:0] kind;
    begin
      if (kind == 2'd0)
        class_thr = (cls == 2'd2) ? `DSB_ON_480 : ((cls == 2'd1) ? `DSB_ON_400 : `DSB_ON_230);
      else if (kind == 2'd1)
        class_thr = (cls == 2'd2) ? `DSB_OFF_480 : ((cls == 2'd1) ? `DSB_OFF_400 : `DSB_OFF_230);
      else
        class_thr = (cls == 2'd2) ? `DSB_OV_480 : ((cls == 2'd1) ? `DSB_OV_400 : `DSB_OV_230);
    end
  endfunction

  // Software registers
  reg [15:0] run_setpoint_reg;
  reg        brake_present_reg;
  reg        enable_removal_response_reg;
  reg        error_response_select_reg;
  reg        phase_loss_response_reg;
  reg [1:0]  supply_class_reg;
  reg [11:0] uv_thr_reg;
  reg [4:0]  irq_stat_reg;
  reg [4:0]  irq_mask_reg;
  reg [4:0]  regen_trim_reg;
  reg        fault_clear_reg;

  // Sequencer state
  reg [1:0]  state_reg;
  reg [31:0] dis_cnt_reg;
  reg [31:0] emrg_cnt_reg;
  reg [31:0] chk_cnt_reg;
  reg [31:0] ramp_cnt_reg;
  reg [15:0] ramp_start_reg;

  // AHB data-phase capture
  reg        dp_wr_reg;
  reg [7:0]  dp_addr_reg;
  reg [31:0] rdata_reg;

  wire addr_ok = hsel & htrans[1] & hready;
  wire wr_now  = dp_wr_reg;
  wire [31:0] wd = hwdata;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;
  assign irq       = |(irq_stat_reg & irq_mask_reg);

  // trim raises both levels within the span
  wire [11:0] on_level  = class_thr(supply_class_reg, 2'd0) + {7'h00, regen_trim_reg};
  wire [11:0] off_level = class_thr(supply_class_reg, 2'd1) + {7'h00, regen_trim_reg};
  wire        chk_tick  = (chk_cnt_reg == CHECK_CYC - 1);
  // overvoltage only seen at the periodic check
  wire        ov_event  = chk_tick & (bus_volts > class_thr(supply_class_reg, 2'd2));
  wire        uv_event  = (bus_volts < uv_thr_reg) & ~undervoltage_fault;
  wire        pl_err    = phase_lost & phase_loss_response_reg;
  wire        rp_event  = (regen_avg_over | regen_peak_over) & ~regen_power_exceeded;
  // controlled braking only with both parameters set
  wire        controlled = enable_removal_response_reg & error_response_select_reg;
  wire        stopped    = speed_rpm <= `DSB_STANDSTILL_RPM;
  wire        brk_event  = brake_present_reg & (state_reg == ST_DELAY) &
                           (stopped | (emrg_cnt_reg >= EMRG_CYC - 1)) & ~brake_out;
  wire [4:0]  ev_vec = {brk_event, rp_event, uv_event, pl_err & ~phase_loss_fault, ov_event};

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= 8'h00;
    end
    else
    begin
      dp_wr_reg   <= addr_ok & hwrite;
      dp_addr_reg <= haddr[7:0];
    end
  end

  // Read data is registered off the address phase, valid in the data phase
  always @(posedge clk)
  begin
    if (!rst_b)
      rdata_reg <= 32'h00000000;
    else if (addr_ok & ~hwrite)
    begin
      if (haddr[7:0] == `DSB_ADDR_CTRL)
        rdata_reg <= {16'h0000, run_setpoint_reg};
      else if (haddr[7:0] == `DSB_ADDR_CFG)
        rdata_reg <= {12'h000, uv_thr_reg, 2'b00, supply_class_reg, phase_loss_response_reg,
                      error_response_select_reg, enable_removal_response_reg, brake_present_reg};
      else if (haddr[7:0] == `DSB_ADDR_STAT)
        rdata_reg <= {20'h00000, state_reg, regen_switch, brake_out, output_stage_on,
                      ready_to_operate_contact, regen_power_exceeded, phase_loss_warning,
                      mains_ready_fault, undervoltage_fault, phase_loss_fault, overvoltage_fault};
      else if (haddr[7:0] == `DSB_ADDR_IRQ)
        rdata_reg <= {27'h0000000, irq_stat_reg};
      else if (haddr[7:0] == `DSB_ADDR_MASK)
        rdata_reg <= {27'h0000000, irq_mask_reg};
      else if (haddr[7:0] == `DSB_ADDR_REGEN)
        rdata_reg <= {27'h0000000, regen_trim_reg};
      else if (haddr[7:0] == `DSB_ADDR_BUS)
        rdata_reg <= {20'h00000, bus_volts};
      else
        rdata_reg <= 32'h00000000;
    end
  end

  // Register writes; status bits: set wins over write-one-to-clear
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      run_setpoint_reg            <= 16'h0000;
      brake_present_reg           <= 1'b0;
      enable_removal_response_reg <= 1'b0;
      error_response_select_reg   <= 1'b1;
      phase_loss_response_reg     <= 1'b1;
      supply_class_reg            <= 2'd1;
      uv_thr_reg                  <= `DSB_UV_RESET;
      irq_stat_reg                <= 5'h00;
      irq_mask_reg                <= 5'h00;
      regen_trim_reg              <= 5'h00;
      fault_clear_reg             <= 1'b0;
    end
    else
    begin
      fault_clear_reg <= 1'b0;
      if (wr_now & (dp_addr_reg == `DSB_ADDR_CTRL))
      begin
        run_setpoint_reg <= wd[15:0];
        fault_clear_reg  <= wd[31];
      end
      else if (wr_now & (dp_addr_reg == `DSB_ADDR_CFG))
      begin
        brake_present_reg           <= wd[0];
        enable_removal_response_reg <= wd[1];
        error_response_select_reg   <= wd[2];
        phase_loss_response_reg     <= wd[3];
        supply_class_reg            <= (wd[5:4] == 2'd3) ? 2'd2 : wd[5:4];
        uv_thr_reg                  <= wd[19:8];
      end
      else if (wr_now & (dp_addr_reg == `DSB_ADDR_MASK))
        irq_mask_reg <= wd[4:0];
      else if (wr_now & (dp_addr_reg == `DSB_ADDR_REGEN))
        regen_trim_reg <= (wd[4:0] > TRIM_MAX[4:0]) ? TRIM_MAX[4:0] : wd[4:0];
      if (wr_now & (dp_addr_reg == `DSB_ADDR_IRQ))
        irq_stat_reg <= (irq_stat_reg & ~wd[4:0]) | ev_vec;
      else
        irq_stat_reg <= irq_stat_reg | ev_vec;
    end
  end

  // Periodic bus check timer
  always @(posedge clk)
    chk_cnt_reg <= (!rst_b | chk_tick) ? 32'h00000000 : chk_cnt_reg + 32'h00000001;

  // Regen chopper with hysteresis
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      regen_switch         <= 1'b0;
      regen_power_exceeded <= 1'b0;
    end
    else
    begin
      // excess regen power latches off the switch
      if (regen_avg_over | regen_peak_over)
        regen_power_exceeded <= 1'b1;
      else if (fault_clear_reg)
        regen_power_exceeded <= 1'b0;
      if (regen_power_exceeded | regen_avg_over | regen_peak_over)
        regen_switch <= 1'b0;
      // switch in at the class threshold
      else if (bus_volts >= on_level)
        regen_switch <= 1'b1;
      else if (bus_volts < off_level)
        regen_switch <= 1'b0;
    end
  end

  // Faults and warnings
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      overvoltage_fault  <= 1'b0;
      phase_loss_fault   <= 1'b0;
      undervoltage_fault <= 1'b0;
      mains_ready_fault  <= 1'b0;
      phase_loss_warning <= 1'b0;
      current_limit_ma   <= 16'hffff;
    end
    else
    begin
      if (ov_event)
        overvoltage_fault <= 1'b1;
      else if (fault_clear_reg)
        overvoltage_fault <= 1'b0;
      if (pl_err)
        phase_loss_fault <= 1'b1;
      else if (fault_clear_reg)
        phase_loss_fault <= 1'b0;
      if (bus_volts < uv_thr_reg)
        undervoltage_fault <= 1'b1;
      else if (fault_clear_reg)
        undervoltage_fault <= 1'b0;
      // warning mode keeps running at 4 A
      phase_loss_warning <= phase_lost & ~phase_loss_response_reg;
      mains_ready_fault  <= phase_lost;
      current_limit_ma   <= (phase_lost & ~phase_loss_response_reg) ? `DSB_CUR_LIMIT_MA : 16'hffff;
    end
  end

  wire fault_any = overvoltage_fault | phase_loss_fault | undervoltage_fault | ov_event | pl_err;
  // with error_response_select_reg set, a fault ramps down even with enable held
  wire to_ramp = fault_any ? error_response_select_reg : (~enable_in & (controlled | brake_present_reg));
  // Ramp in 40 bits so a full-scale setpoint times the count cannot overflow
  wire [39:0] ramp_prod = ramp_start_reg * (ramp_cnt_reg[23:0] + 24'h000001);
  wire [39:0] ramp_drop = ramp_prod / RAMP_CYC;

  // Stop sequencer
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg                <= ST_OFF;
      dis_cnt_reg              <= 32'h00000000;
      emrg_cnt_reg             <= 32'h00000000;
      ramp_cnt_reg             <= 32'h00000000;
      ramp_start_reg           <= 16'h0000;
      setpoint_out             <= 16'h0000;
      output_stage_on          <= 1'b0;
      elec_braking             <= 1'b0;
      brake_out                <= 1'b0;
      ready_to_operate_contact <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          setpoint_out <= run_setpoint_reg;
          // ready opens together with fault shutdown
          if (fault_any)
            ready_to_operate_contact <= 1'b0;
          if (to_ramp)
          begin
            state_reg      <= ST_DELAY;
            elec_braking   <= 1'b1;
            ramp_start_reg <= setpoint_out;
            dis_cnt_reg    <= 32'h00000000;
            emrg_cnt_reg   <= 32'h00000000;
            ramp_cnt_reg   <= 32'h00000000;
          end
          else if (fault_any | !enable_in)
          begin
            state_reg       <= fault_any ? ST_FAULT : ST_OFF;
            output_stage_on <= 1'b0;
            setpoint_out    <= 16'h0000;
          end
        end
        ST_DELAY:
        begin
          // linear ramp to zero over the ramp time
          if (ramp_cnt_reg < RAMP_CYC)
          begin
            ramp_cnt_reg <= ramp_cnt_reg + 32'h00000001;
            setpoint_out <= ramp_start_reg - ramp_drop[15:0];
          end
          else
            setpoint_out <= 16'h0000;
          dis_cnt_reg  <= dis_cnt_reg + 32'h00000001;
          emrg_cnt_reg <= emrg_cnt_reg + 32'h00000001;
          if (ov_event | pl_err)
            ready_to_operate_contact <= 1'b0;
          if (brk_event)
            brake_out <= 1'b1;
          // stage stays on through the delay
          if ((dis_cnt_reg >= DIS_DELAY_CYC - 1) &
              (!brake_present_reg | brake_out | brk_event))
          begin
            output_stage_on <= 1'b0;
            elec_braking    <= 1'b0;
            state_reg       <= fault_any ? ST_FAULT : ST_OFF;
          end
        end
        ST_OFF:
        begin
          setpoint_out             <= 16'h0000;
          ready_to_operate_contact <= ~fault_any;
          if (enable_in & ~fault_any)
          begin
            state_reg       <= ST_RUN;
            output_stage_on <= 1'b1;
            // brake released whenever the output stage switches on
            brake_out       <= 1'b0;
          end
        end
        default:
        begin
          setpoint_out             <= 16'h0000;
          ready_to_operate_contact <= 1'b0;
          if (~fault_any)
            state_reg <= ST_OFF;
        end
      endcase
      // brake never driven without brake function
      if (!brake_present_reg)
        brake_out <= 1'b0;
    end
  end

endmodule

// *** test/dsb_sequencer_chk.sv ***
// Port checker for the stop, brake and regen sequencer.
// Assumes a bind from the bench top and one clock domain.
`timescale 1ns/1ps
module dsb_sequencer_chk
  (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [11:0] bus_volts,
    input wire logic        phase_lost,
    input wire logic        regen_avg_over,
    input wire logic        regen_peak_over,
    input wire logic        output_stage_on,
    input wire logic        elec_braking,
    input wire logic        brake_out,
    input wire logic        regen_switch,
    input wire logic        ready_to_operate_contact,
    input wire logic        overvoltage_fault,
    input wire logic        mains_ready_fault,
    input wire logic        phase_loss_fault,
    input wire logic        phase_loss_warning,
    input wire logic        regen_power_exceeded,
    input wire logic [15:0] current_limit_ma
  );
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_brake_after_ramp: assert property ($rose(brake_out) |-> $past(elec_braking))
    else $error("brake applied outside the stop ramp");
  a_stage_while_brk: assert property (elec_braking |-> output_stage_on)
    else $error("output stage off during braking");
  a_regen_on_level: assert property ($rose(regen_switch) |-> $past(bus_volts) >= 12'h190)
    else $error("regen on below lowest threshold");
  // Highest off threshold is 800 V plus the largest trim
  a_regen_off_level: assert property ($fell(regen_switch) |->
    $past(bus_volts) < 12'h33e || regen_power_exceeded || overvoltage_fault)
    else $error("regen released above off threshold");
  a_exceed_off: assert property (regen_power_exceeded |-> !regen_switch)
    else $error("regen on while power exceeded");
  a_exceed_cause: assert property ((regen_avg_over || regen_peak_over) |=> regen_power_exceeded)
    else $error("power exceeded not reported");
  a_ov_level: assert property ($rose(overvoltage_fault) |-> $past(bus_volts) > 12'h1c2)
    else $error("overvoltage without high bus");
  a_ov_ready_open: assert property ($rose(overvoltage_fault) |-> !ready_to_operate_contact)
    else $error("ready closed at overvoltage");
  a_warn_limit: assert property (phase_loss_warning && $past(phase_loss_warning) |->
    current_limit_ma == 16'h0fa0)
    else $error("current not limited in warning");
  a_warn_cause: assert property (phase_loss_warning |-> $past(phase_lost))
    else $error("warning without phase loss");
  a_pl_ready_open: assert property ($rose(phase_loss_fault) |-> !ready_to_operate_contact)
    else $error("ready closed at phase fault");
  a_mains_follow: assert property (1'b1 |=> mains_ready_fault == $past(phase_lost))
    else $error("mains fault does not follow phase");
  cover property ($rose(brake_out));
  cover property ($rose(regen_switch));
  cover property ($rose(overvoltage_fault));
endmodule

// *** test/dsb_motor_model.sv ***
// Motor with holding brake plus a machine host that watches mains faults.
// Assumes registered sequencer outputs, one clock, rst_b active low.
`timescale 1ns/1ps
module dsb_motor_model
  (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        stall,
    input  wire logic        run_req,
    input  wire logic [15:0] setpoint_out,
    input  wire logic        output_stage_on,
    input  wire logic        elec_braking,
    input  wire logic        brake_out,
    input  wire logic        mains_ready_fault,
    output logic             enable_in,
    output logic      [15:0] speed_rpm
  );
  logic [4:0] watch_reg;
  // host drops enable 20 cycles into a mains fault
  assign enable_in = run_req && watch_reg != 5'h14;
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      speed_rpm <= 16'h0000;
      watch_reg <= 5'h00;
    end
    else
    begin
      watch_reg <= !mains_ready_fault ? 5'h00 : watch_reg + 5'(watch_reg != 5'h14);
      // Stall: the load keeps the shaft turning, so only the timeout can brake
      if (brake_out)
        speed_rpm <= 16'h0000;
      else if (elec_braking)
        speed_rpm <= stall ? speed_rpm : speed_rpm - (speed_rpm > 16'h0014 ? 16'h0014 : speed_rpm);
      else if (output_stage_on)
        speed_rpm <= setpoint_out;
      else if (speed_rpm != 16'h0000)
        speed_rpm <= speed_rpm - 16'h0001;
    end
  end
endmodule

// *** test/tb_drive_stop_brake_regen_sequencer.sv ***
// Self-checking bench for the stop, brake and regen sequencer.
// Assumes the motor model on the far side; counts are shortened.
`timescale 1ns/1ps
`include "dsb_defs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_drive_stop_brake_regen_sequencer;
  localparam int DIS = 100, RMP = 10, EMR = 500, CHC = 4;
  localparam logic [11:0] THR [0:8] = '{`DSB_ON_230, `DSB_ON_400, `DSB_ON_480, `DSB_OFF_230,
    `DSB_OFF_400, `DSB_OFF_480, `DSB_OV_230, `DSB_OV_400, `DSB_OV_480};
  logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, irq, stall, run_req, enable_in;
  logic        phase_lost, regen_avg_over, regen_peak_over, output_stage_on, elec_braking, brake_out;
  logic        regen_switch, ready_to_operate_contact, overvoltage_fault, phase_loss_fault;
  logic        undervoltage_fault, mains_ready_fault, phase_loss_warning, regen_power_exceeded;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] bus_volts;
  logic [15:0] speed_rpm, setpoint_out, current_limit_ma, sp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          n_fail, n_tests, cycles, k, w, m, c, p, tr, t_brk, t_off;
  dsb_sequencer #(.DIS_DELAY_CYC(DIS), .RAMP_CYC(RMP), .EMRG_CYC(EMR), .CHECK_CYC(CHC)) i_dut (.clk, .rst_b,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .enable_in, .speed_rpm, .bus_volts, .phase_lost, .regen_avg_over, .regen_peak_over, .setpoint_out,
    .output_stage_on, .elec_braking, .brake_out, .regen_switch, .ready_to_operate_contact, .overvoltage_fault,
    .phase_loss_fault, .undervoltage_fault, .mains_ready_fault, .phase_loss_warning, .regen_power_exceeded,
    .current_limit_ma, .irq);
  dsb_motor_model i_motor (.clk, .rst_b, .stall, .run_req, .setpoint_out, .output_stage_on, .elec_braking,
    .brake_out, .mains_ready_fault, .enable_in, .speed_rpm);
  function automatic logic [31:0] cfg(input logic b, s, e, f, input logic [1:0] cl);
    return {12'h000, 12'h0c8, 2'b00, cl, f, e, s, b};
  endfunction
  task automatic ahb(input logic wr, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic bus(input logic [11:0] v, input int n);
    @(posedge clk) bus_volts <= v;
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait; a condition that never comes shows up in the next compare
  task automatic run(input logic [31:0] c_word);
    ahb(1'b1, `DSB_ADDR_CFG, c_word);
    ahb(1'b1, `DSB_ADDR_CTRL, {16'h0000, sp});
    @(posedge clk) run_req <= 1'b1;
    for (w = 0; w < 60 && !(output_stage_on === 1'b1 && speed_rpm === sp); w++) @(negedge clk);
  endtask
  task give_verdict;
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  initial
  begin
    {rst_b, hsel, hwrite, stall, run_req, phase_lost, regen_avg_over, regen_peak_over} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    bus_volts = 12'h12c;
    void'($urandom(8));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK("limit", 16'hffff, current_limit_ma)
    `CHK("hresp", 1'b0, hresp)
    ahb(1'b0, `DSB_ADDR_CFG, 0);
    `CHK("cfg", cfg(0, 0, 1, 1, 2'h1), rd)
    ahb(1'b0, 32'h0000_0040, 0);
    `CHK("unmapped", 32'h0000_0000, rd)
    // Modes: brake prompt, brake stalled, controlled without brake, coast
    for (m = 0; m < 4; m++)
    begin
      sp = 16'(16'h0100 + $urandom_range(0, 768));
      @(posedge clk) stall <= (m == 1);
      run(cfg(m < 2, m != 3, m != 3, 1, 2'h1));
      @(posedge clk) run_req <= 1'b0;
      t_brk = -1;
      t_off = -1;
      for (k = 1; k <= EMR + 20 && t_off < 0; k++)
      begin
        @(negedge clk);
        if (k == 2) `CHK("elec_brk", m < 3, elec_braking)
        if (m < 3 && k == RMP / 2) `CHK("ramp", 1'b1, setpoint_out != 0 && setpoint_out < sp)
        if (m < 3 && k == RMP + 2) `CHK("ramp_end", 16'h0000, setpoint_out)
        if (brake_out === 1'b1 && t_brk < 0) t_brk = k;
        if (output_stage_on === 1'b0) t_off = k;
      end
      if (m == 0) `CHK("brk_slow", 1'b1, t_brk > 0 && t_brk < DIS)
      if (m == 0) `CHK("delay", 1'b1, t_off >= DIS && t_off <= DIS + 3)
      if (m == 1) `CHK("brk_to", 1'b1, t_brk >= EMR - 1 && t_brk <= EMR + 3)
      if (m >= 2) `CHK("no_brake", -1, t_brk)
      if (m == 3) `CHK("coast", 1'b1, t_off > 0 && t_off <= 2)
    end
    for (c = 0; c < 3; c++)
    begin
      bus(12'h12c, 1);
      tr = $urandom_range(0, 30);
      ahb(1'b1, `DSB_ADDR_CFG, cfg(0, 0, 1, 1, 2'(c)));
      ahb(1'b1, `DSB_ADDR_REGEN, tr);
      ahb(1'b1, `DSB_ADDR_CTRL, 32'h8000_0000);
      bus(12'(THR[c] + tr - 1), 3);
      `CHK("regen_low", 1'b0, regen_switch)
      bus(12'(THR[c] + tr), 3);
      `CHK("regen_on", 1'b1, regen_switch)
      bus(12'(THR[3 + c] + tr), 3);
      `CHK("regen_hyst", 1'b1, regen_switch)
      bus(12'(THR[3 + c] + tr - 1), 3);
      `CHK("regen_off", 1'b0, regen_switch)
      bus(THR[6 + c], 3 * CHC);
      `CHK("ov_edge", 1'b0, overvoltage_fault)
      bus(THR[6 + c] + 12'h001, CHC + 3);
      `CHK("ov", 1'b1, overvoltage_fault)
      `CHK("ov_ready", 1'b0, ready_to_operate_contact)
    end
    bus(12'h12c, 1);
    ahb(1'b1, `DSB_ADDR_CFG, cfg(0, 1, 1, 1, 2'h1));
    ahb(1'b1, `DSB_ADDR_REGEN, 32'h0000_001f);
    ahb(1'b0, `DSB_ADDR_REGEN, 0);
    `CHK("trim_clamp", {20'h00000, `DSB_ON_SPAN}, rd)
    ahb(1'b1, `DSB_ADDR_REGEN, 0);
    ahb(1'b1, `DSB_ADDR_CTRL, 32'h8000_0000);
    for (p = 0; p < 2; p++)
    begin
      bus(`DSB_ON_400, 3);
      ahb(1'b1, `DSB_ADDR_IRQ, 32'h0000_001f);
      ahb(1'b1, `DSB_ADDR_MASK, 0);
      @(posedge clk) {regen_peak_over, regen_avg_over} <= p ? 2'b10 : 2'b01;
      @(posedge clk) {regen_peak_over, regen_avg_over} <= 2'b00;
      repeat (2) @(negedge clk);
      `CHK("exceeded", 2'b10, {regen_power_exceeded, regen_switch})
      `CHK("irq_masked", 1'b0, irq)
      ahb(1'b1, `DSB_ADDR_MASK, 32'h0000_0008);
      @(negedge clk);
      `CHK("irq_on", 1'b1, irq)
      ahb(1'b1, `DSB_ADDR_IRQ, 32'h0000_0008);
      @(negedge clk);
      `CHK("irq_clr", 1'b0, irq)
      ahb(1'b1, `DSB_ADDR_CTRL, 32'h8000_0000);
      repeat (2) @(negedge clk);
      `CHK("exc_clr", 1'b0, regen_power_exceeded)
    end
    bus(12'h12c, 1);
    sp = 16'h0200;
    ahb(1'b0, `DSB_ADDR_BUS, 0);
    `CHK("bus_rd", 32'h0000_012c, rd)
    for (p = 0; p < 2; p++)
    begin
      run(cfg(0, 1, 1, p[0], 2'h1));
      @(posedge clk) phase_lost <= 1'b1;
      repeat (3) @(negedge clk);
      `CHK("mains", 1'b1, mains_ready_fault)
      `CHK("pl_warn", {~p[0], 1'b1}, {phase_loss_warning, elec_braking | output_stage_on})
      if (p == 0) `CHK("pl_limit", 16'h0fa0, current_limit_ma)
      if (p == 1) `CHK("pl_fault", 3'b101, {phase_loss_fault, ready_to_operate_contact, elec_braking})
      repeat (22) @(negedge clk);
      `CHK("host_stop", 1'b1, elec_braking)
      @(posedge clk) phase_lost <= 1'b0;
      run_req <= 1'b0;
      for (w = 0; w < 300 && output_stage_on !== 1'b0; w++) @(negedge clk);
      ahb(1'b1, `DSB_ADDR_CTRL, 32'h8000_0000);
    end
    run(cfg(0, 0, 0, 1, 2'h1));
    bus(12'h0c8, 3);
    `CHK("uv_edge", 1'b0, undervoltage_fault)
    bus(12'h0c7, 3);
    `CHK("uv", 2'b10, {undervoltage_fault, output_stage_on})
    give_verdict();
  end
endmodule
bind dsb_sequencer dsb_sequencer_chk i_chk (.clk, .rst_b, .bus_volts, .phase_lost, .regen_avg_over,
  .regen_peak_over, .output_stage_on, .elec_braking, .brake_out, .regen_switch, .ready_to_operate_contact,
  .overvoltage_fault, .mains_ready_fault, .phase_loss_fault, .phase_loss_warning, .regen_power_exceeded,
  .current_limit_ma);
